// *** hdl/rdv_pkg.sv ***
package rdv_pkg;
  // register offsets within the 20-bit board window
  localparam logic [19:0] OFS_MOTHER_ID = 20'h0_0000;
  localparam logic [19:0] OFS_MOTHER_CTRL = 20'h0_0004;
  localparam logic [19:0] OFS_MOTHER_STATUS = 20'h0_0008;
  localparam logic [19:0] OFS_CARD_ID = 20'h0_000C;
  localparam logic [19:0] OFS_CARD_CTRL = 20'h0_0010;
  localparam logic [19:0] OFS_CARD_STATUS = 20'h0_0014;
  localparam logic [19:0] OFS_PULSE = 20'h0_0018;
  localparam logic [19:0] OFS_REV_VME = 20'h0_001C;
  localparam logic [19:0] OFS_PROGRAM = 20'h0_0020;
  localparam logic [19:0] OFS_CRATE_MOD = 20'h0_0024;
  localparam logic [19:0] OFS_SLICE = 20'h0_0028;
  localparam logic [19:0] OFS_REGION = 20'h0_002C;
  localparam logic [19:0] OFS_IRQ_CTRL = 20'h0_0030;
  localparam logic [19:0] OFS_REV_CTRL = 20'h0_0040;
  localparam logic [19:0] OFS_REV_DATA1 = 20'h0_0060;
  localparam logic [19:0] OFS_WCNT1 = 20'h0_0064;
  localparam logic [19:0] OFS_WCNT2 = 20'h0_0068;
  localparam logic [19:0] OFS_REV_DATA2 = 20'h0_0070;
  localparam logic [19:0] OFS_WCNT3 = 20'h0_0074;
  localparam logic [19:0] OFS_WCNT4 = 20'h0_0078;
  localparam logic [19:0] OFS_REV_LINK = 20'h0_0080;
  // accepted address modifiers
  localparam logic [5:0] AM_A24_USER = 6'h39;
  localparam logic [5:0] AM_A24_SUPER = 6'h3D;
  // control word fields
  localparam int CR_THR_LSB = 0;
  localparam int CR_XOFF_BIT = 8;
  localparam int CR_CLK_LSB = 9;
  localparam logic [10:0] CR_RST = 11'h000;
  localparam logic [1:0] CLK_ONBOARD = 2'h0;
  localparam logic [1:0] CLK_DESKEW1 = 2'h1;
  localparam logic [1:0] CLK_DESKEW2 = 2'h2;
  localparam logic [1:0] CLK_PLAIN = 2'h3;
  // status word fields
  localparam int ST_FULL_LSB = 0;
  localparam int ST_EMPTY_LSB = 4;
  localparam int ST_LOADED_LSB = 8;
  localparam int ST_LINK_BIT = 11;
  localparam int ST_TREADY_BIT = 12;
  // pulse register bits
  localparam int PB_GLOBAL = 0;
  localparam int PB_TIMING = 1;
  localparam int PB_LINKRX = 2;
  localparam int PB_FIFO_CLR = 3;
  localparam int PB_RETX = 4;
  localparam int PULSE_BITS = 5;
  // pulse timing: least time, rounded up
  localparam int CLK_PERIOD_NS = 8;
  localparam int PULSE_NS = 200;
  localparam int PULSE_CYC = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // revision word layout
  localparam int REV_NUM_LSB = 24;
  localparam int REV_FUNC_LSB = 16;
  localparam logic [7:0] FN_LINK = 8'h30;
  localparam logic [7:0] FN_DATA = 8'h31;
  localparam logic [7:0] FN_CTRL = 8'h32;
  localparam logic [7:0] FN_VME = 8'h33;
  // slice count legal range
  localparam logic [2:0] SLICE_MIN = 3'h1;
  localparam logic [2:0] SLICE_MAX = 3'h5;
  // mezzanine bus-mode lines driven by the board
  localparam logic [2:0] BUSMODE_DRIVE = 3'h0;
endpackage

// *** hdl/rdv_regs.sv ***
`timescale 1ns/1ns
module rdv_regs #(
  parameter logic [15:0] MODULE_TYPE = 16'h5A5A, // arbitrary value
  parameter logic [7:0] BOARD_SERIAL = 8'h01,
  parameter logic [3:0] BOARD_ISSUE = 4'h1,
  parameter logic [7:0] REV_VME = 8'h01,
  parameter logic [7:0] REV_CTRL = 8'h01,
  parameter logic [7:0] REV_DATA = 8'h01,
  parameter logic [7:0] REV_LINK = 8'h01,
  parameter int WCNT_W = 18,
  parameter int REGION_W = 16
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [23:0] vme_addr_i,
  input wire logic [5:0] vme_am_i,
  input wire logic vme_as_n_i,
  input wire logic vme_ds_n_i,
  input wire logic vme_write_n_i,
  input wire logic vme_sysreset_n_i,
  input wire logic [31:0] vme_data_i,
  output logic [31:0] vme_data_o,
  output logic vme_data_oe_n_o,
  output logic vme_dtack_n_o,
  output logic vme_dtack_oe_n_o,
  input wire logic [3:0] base_switch_i,
  input wire logic [3:0] buffer_full_i,
  input wire logic [3:0] buffer_empty_i,
  input wire logic control_fpga_loaded_i,
  input wire logic data_fpga1_loaded_i,
  input wire logic data_fpga2_loaded_i,
  input wire logic output_link_fpga_ready_i,
  input wire logic timing_receiver_ready_i,
  input wire logic timing_receiver_present_i,
  input wire logic [3:0] link_locked_i,
  input wire logic [4:0] card_serial_i,
  input wire logic card_present_n_i,
  input wire logic [WCNT_W-1:0] wr_count1_i,
  input wire logic [WCNT_W-1:0] wr_count2_i,
  input wire logic [WCNT_W-1:0] wr_count3_i,
  input wire logic [WCNT_W-1:0] wr_count4_i,
  output logic [7:0] suppress_threshold_o,
  output logic software_xoff_o,
  output logic [1:0] clock_source_select_o,
  output logic receiver_divide_select_o,
  output logic global_reset_pulse_o,
  output logic timing_receiver_reset_pulse_o,
  output logic link_receiver_reset_pulse_o,
  output logic fifo_clear_pulse_o,
  output logic fifo_retransmit_pulse_o,
  output logic [23:0] crate_and_module_number_o,
  output logic [2:0] slice_count_o,
  output logic [REGION_W-1:0] region_limit_o,
  output logic bus_config_enable_o,
  output logic [2:0] busmode_o
);
  localparam int PIN_W = 94;

  typedef enum logic [1:0] {ST_IDLE, ST_DO, ST_ACK} rdv_bus_e;

  // pin synchroniser: active-low pins inverted first so zero means idle
  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] pin_s1_r;
  logic [PIN_W-1:0] pin_s2_r;
  logic [PIN_W-1:0] pin_s3_r;
  logic [PIN_W-1:0] pin_r;
  logic [PIN_W-1:0] pin_nxt;

  assign pin_raw = {~vme_ds_n_i, ~vme_as_n_i, ~vme_write_n_i,
                    ~vme_sysreset_n_i, vme_am_i, vme_addr_i, vme_data_i,
                    base_switch_i, buffer_full_i, buffer_empty_i,
                    data_fpga2_loaded_i, data_fpga1_loaded_i,
                    control_fpga_loaded_i, output_link_fpga_ready_i,
                    timing_receiver_ready_i, timing_receiver_present_i,
                    link_locked_i, card_serial_i, ~card_present_n_i};

  // a bit moves only once the second and third stage agree
  assign pin_nxt = (pin_s2_r & pin_s3_r) | (pin_r & (pin_s2_r | pin_s3_r));

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
      pin_s3_r <= '0;
      pin_r <= '0;
    end else begin
      pin_s1_r <= pin_raw;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      pin_r <= pin_nxt;
    end
  end

  logic ds_act;
  logic as_act;
  logic wr_act;
  logic sysrst_act;
  logic [5:0] am_w;
  logic [23:0] addr_w;
  logic [31:0] wdata_w;
  logic [3:0] base_w;
  logic [3:0] full_w;
  logic [3:0] empty_w;
  logic [2:0] loaded_w;
  logic link_rdy_w;
  logic tr_rdy_w;
  logic tr_present_w;
  logic [3:0] lock_w;
  logic [4:0] serial_w;
  logic card_here_w;

  assign {ds_act, as_act, wr_act, sysrst_act, am_w, addr_w, wdata_w,
          base_w, full_w, empty_w, loaded_w, link_rdy_w, tr_rdy_w,
          tr_present_w, lock_w, serial_w, card_here_w} = pin_r;

  // address decode
  logic board_sel;
  logic am_ok;
  logic [19:0] ofs;
  assign am_ok = (am_w == rdv_pkg::AM_A24_USER) ||
                 (am_w == rdv_pkg::AM_A24_SUPER);
  assign board_sel = ds_act && as_act && am_ok && (addr_w[23:20] == base_w);
  assign ofs = addr_w[19:0];

  rdv_bus_e state_r;
  logic wr_stb;
  logic rd_stb;
  assign wr_stb = (state_r == ST_DO) && wr_act;
  assign rd_stb = (state_r == ST_DO) && !wr_act;

  logic hit_ctrl;
  logic hit_cctrl;
  logic hit_pulse;
  logic hit_prog;
  logic hit_crate;
  logic hit_slice;
  logic hit_region;
  logic hit_irq;
  assign hit_ctrl = ofs == rdv_pkg::OFS_MOTHER_CTRL;
  assign hit_cctrl = ofs == rdv_pkg::OFS_CARD_CTRL;
  assign hit_pulse = ofs == rdv_pkg::OFS_PULSE;
  assign hit_prog = ofs == rdv_pkg::OFS_PROGRAM;
  assign hit_crate = ofs == rdv_pkg::OFS_CRATE_MOD;
  assign hit_slice = ofs == rdv_pkg::OFS_SLICE;
  assign hit_region = ofs == rdv_pkg::OFS_REGION;
  assign hit_irq = ofs == rdv_pkg::OFS_IRQ_CTRL;

  // pulse generators
  logic [rdv_pkg::PULSE_BITS-1:0] pls_r;
  logic [rdv_pkg::PULSE_BITS-1:0] pls_trig;
  logic soft_clr;
  assign soft_clr = pls_r[rdv_pkg::PB_GLOBAL];

  genvar gi;
  generate
    for (gi = 0; gi < rdv_pkg::PULSE_BITS; gi++) begin : g_pulse
      logic [4:0] cnt_r;
      logic [4:0] cnt_nxt;
      if (gi == rdv_pkg::PB_GLOBAL) begin : g_glob
        // system reset keeps retriggering, so the pulse outlasts it
        assign pls_trig[gi] = (wr_stb && hit_pulse && wdata_w[gi]) ||
                              sysrst_act;
      end else begin : g_other
        assign pls_trig[gi] = wr_stb && hit_pulse && wdata_w[gi];
      end
      assign cnt_nxt = pls_trig[gi] ? 5'(rdv_pkg::PULSE_CYC) :
                       (cnt_r != 5'h0) ? cnt_r - 5'h1 : cnt_r;
      always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
          cnt_r <= 5'h0;
          pls_r[gi] <= 1'b0;
        end else begin
          cnt_r <= cnt_nxt;
          pls_r[gi] <= pls_trig[gi] || (cnt_r > 5'h1);
        end
      end
    end
  endgenerate

  // control registers
  logic [10:0] ctrl_r;
  logic [10:0] ctrl_nxt;
  logic [1:0] clk_req;
  logic tr_ok;
  logic [1:0] clk_store;
  logic cctrl_r;
  logic [31:0] prog_r;
  logic [23:0] crate_r;
  logic [2:0] slice_r;
  logic [REGION_W-1:0] region_r;
  logic [31:0] irq_r;
  logic slice_ok;

  assign clk_req = wdata_w[rdv_pkg::CR_CLK_LSB +: 2];
  assign tr_ok = tr_present_w && tr_rdy_w;
  // receiver clocks refused when receiver cannot deliver one
  assign clk_store = tr_ok ? clk_req : rdv_pkg::CLK_ONBOARD;
  assign ctrl_nxt = {clk_store, wdata_w[rdv_pkg::CR_XOFF_BIT],
                     wdata_w[rdv_pkg::CR_THR_LSB +: 8]};
  assign slice_ok = (wdata_w[2:0] >= rdv_pkg::SLICE_MIN) &&
                    (wdata_w[2:0] <= rdv_pkg::SLICE_MAX) &&
                    (wdata_w[31:3] == 29'h0);

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctrl_r <= rdv_pkg::CR_RST;
      cctrl_r <= 1'b0;
      prog_r <= 32'h0000_0000;
      crate_r <= 24'h00_0000;
      slice_r <= 3'h0;
      region_r <= '0;
      irq_r <= 32'h0000_0000;
    end else if (soft_clr) begin
      ctrl_r <= rdv_pkg::CR_RST;
      cctrl_r <= 1'b0;
      prog_r <= 32'h0000_0000;
      crate_r <= 24'h00_0000;
      slice_r <= 3'h0;
      region_r <= '0;
      irq_r <= 32'h0000_0000;
    end else if (wr_stb) begin
      if (hit_ctrl) begin
        ctrl_r <= ctrl_nxt;
      end
      if (hit_cctrl) begin
        cctrl_r <= wdata_w[0];
      end
      if (hit_prog) begin
        prog_r <= wdata_w;
      end
      if (hit_crate) begin
        crate_r <= wdata_w[23:0];
      end
      if (hit_slice && slice_ok) begin
        slice_r <= wdata_w[2:0];
      end
      if (hit_region) begin
        region_r <= wdata_w[REGION_W-1:0];
      end
      if (hit_irq) begin
        irq_r <= wdata_w;
      end
    end
  end

  // read-back words
  logic [31:0] id_w;
  logic [31:0] status_w;
  logic [31:0] card_id_w;
  logic [31:0] card_st_w;
  logic [31:0] rd_mux;

  function automatic logic [31:0] rev_word(input logic [7:0] rev,
                                           input logic [7:0] fn);
    rev_word = {rev, fn, MODULE_TYPE};
  endfunction

  assign id_w = {4'h0, BOARD_ISSUE, BOARD_SERIAL, MODULE_TYPE};
  // upper status bits stay zero
  assign status_w = {19'h0_0000, tr_rdy_w, link_rdy_w, loaded_w,
                     empty_w, full_w};
  // no card fitted reads as serial zero
  assign card_id_w = {27'h000_0000, card_here_w ? serial_w : 5'h00};
  assign card_st_w = {28'h000_0000, lock_w};

  assign rd_mux =
    (ofs == rdv_pkg::OFS_MOTHER_ID) ? id_w :
    hit_ctrl ? {21'h00_0000, ctrl_r} :
    (ofs == rdv_pkg::OFS_MOTHER_STATUS) ? status_w :
    (ofs == rdv_pkg::OFS_CARD_ID) ? card_id_w :
    hit_cctrl ? {31'h0000_0000, cctrl_r} :
    (ofs == rdv_pkg::OFS_CARD_STATUS) ? card_st_w :
    (ofs == rdv_pkg::OFS_REV_VME) ? rev_word(REV_VME, rdv_pkg::FN_VME) :
    (ofs == rdv_pkg::OFS_REV_CTRL) ? rev_word(REV_CTRL, rdv_pkg::FN_CTRL) :
    (ofs == rdv_pkg::OFS_REV_DATA1) ? rev_word(REV_DATA, rdv_pkg::FN_DATA) :
    (ofs == rdv_pkg::OFS_REV_DATA2) ? rev_word(REV_DATA, rdv_pkg::FN_DATA) :
    (ofs == rdv_pkg::OFS_REV_LINK) ? rev_word(REV_LINK, rdv_pkg::FN_LINK) :
    hit_prog ? prog_r :
    hit_crate ? {8'h00, crate_r} :
    hit_slice ? {29'h0000_0000, slice_r} :
    hit_region ? 32'(region_r) :
    hit_irq ? irq_r :
    (ofs == rdv_pkg::OFS_WCNT1) ? 32'(wr_count1_i) :
    (ofs == rdv_pkg::OFS_WCNT2) ? 32'(wr_count2_i) :
    (ofs == rdv_pkg::OFS_WCNT3) ? 32'(wr_count3_i) :
    (ofs == rdv_pkg::OFS_WCNT4) ? 32'(wr_count4_i) :
    32'h0000_0000; // pulse and unmapped read as zero

  // bus handshake: every selected cycle gets an acknowledge
  rdv_bus_e state_nxt;
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (board_sel) begin
          state_nxt = ST_DO;
        end
      end
      ST_DO: begin
        state_nxt = ST_ACK;
      end
      ST_ACK: begin
        if (!ds_act) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_r <= ST_IDLE;
      vme_data_o <= 32'h0000_0000;
      vme_data_oe_n_o <= 1'b1;
      vme_dtack_oe_n_o <= 1'b1;
    end else begin
      state_r <= state_nxt;
      if (rd_stb) begin
        vme_data_o <= rd_mux;
        vme_data_oe_n_o <= 1'b0;
      end else if (state_nxt == ST_IDLE) begin
        vme_data_oe_n_o <= 1'b1;
      end
      // status words have no write path, so writes there just ack
      vme_dtack_oe_n_o <= !(state_nxt == ST_ACK);
    end
  end

  // open-drain acknowledge: only ever pulls low
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      vme_dtack_n_o <= 1'b0;
      busmode_o <= rdv_pkg::BUSMODE_DRIVE;
    end else begin
      vme_dtack_n_o <= 1'b0;
      busmode_o <= rdv_pkg::BUSMODE_DRIVE;
    end
  end

  assign suppress_threshold_o = ctrl_r[rdv_pkg::CR_THR_LSB +: 8];
  assign software_xoff_o = ctrl_r[rdv_pkg::CR_XOFF_BIT];
  assign clock_source_select_o = ctrl_r[rdv_pkg::CR_CLK_LSB +: 2];
  assign receiver_divide_select_o = cctrl_r;
  assign global_reset_pulse_o = pls_r[rdv_pkg::PB_GLOBAL];
  assign timing_receiver_reset_pulse_o = pls_r[rdv_pkg::PB_TIMING];
  assign link_receiver_reset_pulse_o = pls_r[rdv_pkg::PB_LINKRX];
  assign fifo_clear_pulse_o = pls_r[rdv_pkg::PB_FIFO_CLR];
  assign fifo_retransmit_pulse_o = pls_r[rdv_pkg::PB_RETX];
  assign crate_and_module_number_o = crate_r;
  assign slice_count_o = slice_r;
  assign region_limit_o = region_r;
  assign bus_config_enable_o = prog_r[0];

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  property p_clk_refuse;
    wr_stb && hit_ctrl && !tr_ok && !soft_clr |=>
      clock_source_select_o == rdv_pkg::CLK_ONBOARD;
  endproperty
  a_clk_refuse: assert property (p_clk_refuse)
    else $error("receiver clock stored while receiver not ready");

  property p_clk_accept;
    wr_stb && hit_ctrl && tr_ok && !soft_clr |=>
      clock_source_select_o == $past(wdata_w[10:9]);
  endproperty
  a_clk_accept: assert property (p_clk_accept)
    else $error("clock source not stored as written");

  property p_glob_clears;
    $rose(global_reset_pulse_o) |=> clock_source_select_o == 2'h0 &&
      !receiver_divide_select_o;
  endproperty
  a_glob_clears: assert property (p_glob_clears)
    else $error("global reset left control state set");

  property p_status_read;
    rd_stb && ofs == rdv_pkg::OFS_MOTHER_STATUS |=>
      vme_data_o == {19'h0_0000, $past(tr_rdy_w), $past(link_rdy_w),
      $past(loaded_w), $past(empty_w), $past(full_w)};
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("status word does not match flags");

  property p_card_id;
    rd_stb && ofs == rdv_pkg::OFS_CARD_ID |=> vme_data_o[31:5] == 27'h0;
  endproperty
  a_card_id: assert property (p_card_id)
    else $error("card identity upper bits not zero");

  property p_div_sel;
    wr_stb && hit_cctrl && !soft_clr |=>
      receiver_divide_select_o == $past(wdata_w[0]);
  endproperty
  a_div_sel: assert property (p_div_sel)
    else $error("divide select not following control bit");

  property p_lock_read;
    rd_stb && ofs == rdv_pkg::OFS_CARD_STATUS |=>
      vme_data_o == {28'h000_0000, $past(lock_w)};
  endproperty
  a_lock_read: assert property (p_lock_read)
    else $error("lock bits misread");

  property p_glob_len;
    $rose(global_reset_pulse_o) |-> ##24 global_reset_pulse_o;
  endproperty
  a_glob_len: assert property (p_glob_len)
    else $error("global reset pulse too short");

  property p_timing_len;
    $rose(timing_receiver_reset_pulse_o) |->
      timing_receiver_reset_pulse_o[*8] ##16 timing_receiver_reset_pulse_o;
  endproperty
  a_timing_len: assert property (p_timing_len)
    else $error("timing receiver reset pulse too short");

  property p_pulse_read;
    rd_stb && hit_pulse |=> vme_data_o == 32'h0000_0000;
  endproperty
  a_pulse_read: assert property (p_pulse_read)
    else $error("pulse register read nonzero");

  property p_ack;
    state_r == ST_IDLE && board_sel |-> ##[1:2] !vme_dtack_oe_n_o;
  endproperty
  a_ack: assert property (p_ack)
    else $error("selected access not acknowledged");

  property p_ro_write;
    wr_stb && ofs == rdv_pkg::OFS_MOTHER_STATUS && !soft_clr |=>
      $stable(ctrl_r) && $stable(cctrl_r);
  endproperty
  a_ro_write: assert property (p_ro_write)
    else $error("write to status changed state");

  c_ctrl_write: cover property (wr_stb && hit_ctrl && tr_ok);
  c_clk_refused: cover property (wr_stb && hit_ctrl && !tr_ok &&
                                 wdata_w[10:9] != 2'h0);
  c_status_read: cover property (rd_stb &&
                                 ofs == rdv_pkg::OFS_MOTHER_STATUS);
  c_glob_pulse: cover property ($fell(global_reset_pulse_o));
endmodule

// *** dv/rdv_host.sv ***
`timescale 1ns/1ns
module rdv_host (
  input wire logic clk_i,
  input wire logic [31:0] rdata_i,
  input wire logic ack_n_i,
  output logic [23:0] addr_o,
  output logic [5:0] am_o,
  output logic as_n_o,
  output logic ds_n_o,
  output logic write_n_o,
  output logic [31:0] wdata_o,
  output logic rd_valid_o,
  output logic [31:0] rd_data_o,
  output logic timeout_o
);
  initial begin
    {addr_o, am_o, wdata_o, rd_data_o} = '0;
    {as_n_o, ds_n_o, write_n_o, rd_valid_o, timeout_o} = 5'h1C;
  end
  // bounded so a silent slave shows up instead of hanging
  task automatic wait_ack(input logic lvl);
    int n;
    n = 0;
    while (ack_n_i !== lvl && n < 40) begin
      @(posedge clk_i);
      n++;
    end
    if (n == 40) timeout_o = 1'b1;
  endtask
  task automatic access(input logic wr, input logic [23:0] a,
                        input logic [31:0] d);
    @(posedge clk_i);
    #1;
    addr_o = a;
    am_o = a[2] ? rdv_pkg::AM_A24_SUPER : rdv_pkg::AM_A24_USER;
    write_n_o = ~wr;
    wdata_o = d;
    {as_n_o, ds_n_o} = 2'h0;
    @(posedge clk_i);
    wait_ack(1'b0);
    rd_data_o = rdata_i;
    #1;
    // released lines must not keep showing the old value
    {as_n_o, ds_n_o} = 2'h3;
    addr_o = ~a;
    wdata_o = ~d;
    rd_valid_o = ~wr;
    @(posedge clk_i);
    #1;
    rd_valid_o = 1'b0;
    wait_ack(1'b1);
  endtask
endmodule

// *** dv/testbench.sv ***
`timescale 1ns/1ns
module testbench;
  localparam logic [15:0] MTYPE = 16'h5A5A; // arbitrary value
  localparam logic [19:0] OFS_ST = rdv_pkg::OFS_MOTHER_STATUS;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic srst_n = 1'b1, card_n = 1'b1, lnk = 1'b0;
  logic [3:0] full = '0, empty = '0, lock = '0;
  logic [2:0] ld = '0;
  logic [1:0] trx = '0, c;
  logic [4:0] ser = '0;
  logic [3:0][17:0] wc = '0;
  logic [15:0] lfsr = 16'hFDF3, r;
  logic [31:0] e;
  int n_errors = 0, comparisons = 0;
  int pcnt [5];
  logic [31:0] exp_q [$];
  string nm_q [$];
  logic [19:0] wofs [4] = '{rdv_pkg::OFS_WCNT1, rdv_pkg::OFS_WCNT2,
    rdv_pkg::OFS_WCNT3, rdv_pkg::OFS_WCNT4};
  logic [19:0] rofs [5] = '{rdv_pkg::OFS_REV_VME, rdv_pkg::OFS_REV_CTRL,
    rdv_pkg::OFS_REV_DATA1, rdv_pkg::OFS_REV_DATA2, rdv_pkg::OFS_REV_LINK};
  logic [7:0] fn [5] = '{rdv_pkg::FN_VME, rdv_pkg::FN_CTRL,
    rdv_pkg::FN_DATA, rdv_pkg::FN_DATA, rdv_pkg::FN_LINK};
  wire [23:0] addr, crate;
  wire [5:0] am;
  wire as_n, ds_n, wr_n, rdv, tmo, ack_n, div, cfg, xoff, doe_n, dtk_n;
  wire [31:0] wd, rdat, rd_d;
  wire [1:0] csel;
  wire [4:0] pls;
  wire [2:0] slice, bmode;
  wire [15:0] region;
  wire [7:0] thr;
  rdv_host u_host (.clk_i(clk_i), .rdata_i(rdat), .ack_n_i(ack_n),
    .addr_o(addr), .am_o(am), .as_n_o(as_n), .ds_n_o(ds_n),
    .write_n_o(wr_n), .wdata_o(wd), .rd_valid_o(rdv), .rd_data_o(rd_d),
    .timeout_o(tmo));
  rdv_regs #(.MODULE_TYPE(MTYPE)) i_rdv_regs (.clk_i(clk_i),
    .sys_rst_i(sys_rst_i), .vme_addr_i(addr), .vme_am_i(am),
    .vme_as_n_i(as_n), .vme_ds_n_i(ds_n), .vme_write_n_i(wr_n),
    .vme_sysreset_n_i(srst_n), .vme_data_i(wd), .vme_data_o(rdat),
    .vme_data_oe_n_o(doe_n), .vme_dtack_n_o(dtk_n), .vme_dtack_oe_n_o(ack_n),
    .base_switch_i(4'h3), .buffer_full_i(full), .buffer_empty_i(empty),
    .control_fpga_loaded_i(ld[0]), .data_fpga1_loaded_i(ld[1]),
    .data_fpga2_loaded_i(ld[2]), .output_link_fpga_ready_i(lnk),
    .timing_receiver_ready_i(trx[0]), .timing_receiver_present_i(trx[1]),
    .link_locked_i(lock), .card_serial_i(ser), .card_present_n_i(card_n),
    .wr_count1_i(wc[0]), .wr_count2_i(wc[1]), .wr_count3_i(wc[2]),
    .wr_count4_i(wc[3]), .suppress_threshold_o(thr), .software_xoff_o(xoff),
    .clock_source_select_o(csel), .receiver_divide_select_o(div),
    .global_reset_pulse_o(pls[0]), .timing_receiver_reset_pulse_o(pls[1]),
    .link_receiver_reset_pulse_o(pls[2]), .fifo_clear_pulse_o(pls[3]),
    .fifo_retransmit_pulse_o(pls[4]), .crate_and_module_number_o(crate),
    .slice_count_o(slice), .region_limit_o(region),
    .bus_config_enable_o(cfg), .busmode_o(bmode));
  always #4 clk_i = ~clk_i;
  function logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction
  task automatic check(input string nm, input logic [31:0] ex, got);
    comparisons++;
    if (got !== ex) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic rd(input string nm, input logic [19:0] o, logic [31:0] ex);
    exp_q.push_back(ex);
    nm_q.push_back(nm);
    u_host.access(1'b0, {4'h3, o}, 32'h0);
  endtask
  task automatic wr(input logic [19:0] o, input logic [31:0] d);
    u_host.access(1'b1, {4'h3, o}, d);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clk_i) begin
    for (int k = 0; k < 5; k++) pcnt[k] += int'(pls[k]);
    if (rdv === 1'b1) begin
      check(nm_q.pop_front(), exp_q.pop_front(), rd_d);
      check("data drive", 32'h0, 32'(doe_n));
    end
  end
  // whole run is some three thousand cycles; this leaves a wide margin
  initial begin
    #400000;
    n_errors++;
    stop_test();
  end
  initial begin
    tick(3);
    sys_rst_i = 1'b0;
    rd("ctrl", rdv_pkg::OFS_MOTHER_CTRL, 32'h0);
    rd("unmapped", 20'h0_0090, 32'h0);
    check("clock pin", 32'h0, 32'(csel));
    check("busmode", 32'h0, 32'(bmode));
    check("program", 32'h0, 32'(cfg));
    check("ack level", 32'h0, 32'(dtk_n));
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      tick(1);
      r = rnd();
      {full, empty, ld, lnk, trx[0]} = r[12:0];
      {lock, card_n, ser} = r[15:6];
      wc = {r, r, r, r, r[7:0]};
      tick(8);
      e = {19'h0, trx[0], lnk, ld, empty, full};
      rd("status", OFS_ST, e);
      wr(rdv_pkg::OFS_MOTHER_STATUS, ~e);
      rd("status kept", rdv_pkg::OFS_MOTHER_STATUS, e);
      e = card_n ? 32'h0 : {27'h0, ser};
      rd("card id", rdv_pkg::OFS_CARD_ID, e);
      rd("card status", rdv_pkg::OFS_CARD_STATUS, {28'h0, lock});
      for (int k = 0; k < 4; k++) begin
        rd("counter", wofs[k], {14'h0, wc[k]});
      end
    end
    $display("test status done");
    for (int i = 0; i < 16; i++) begin
      tick(1);
      trx = i[3:2];
      tick(8);
      r = rnd();
      c = (trx == 2'h3) ? i[1:0] : 2'h0;
      wr(rdv_pkg::OFS_MOTHER_CTRL, {21'h0, i[1:0], r[8], r[7:0]});
      e = {21'h0, c, r[8], r[7:0]};
      rd("ctrl", rdv_pkg::OFS_MOTHER_CTRL, e);
      check("clock pin", 32'(c), 32'(csel));
      check("control pins", {23'h0, e[8:0]}, {23'h0, xoff, thr});
      wr(rdv_pkg::OFS_CARD_CTRL, 32'(i[0]));
      check("divide pin", 32'(i[0]), 32'(div));
      rd("card ctrl", rdv_pkg::OFS_CARD_CTRL, 32'(i[0]));
    end
    $display("test clock done");
    for (int b = 0; b < 6; b++) begin
      pcnt = '{default: 0};
      wr(rdv_pkg::OFS_PULSE, (b < 5) ? 32'h1 << b : 32'h0);
      tick(40);
      for (int k = 0; k < 5; k++) begin
        e = (k == b) ? 32'(rdv_pkg::PULSE_CYC) : 32'h0;
        check("pulse", e, 32'(pcnt[k]));
      end
      rd("pulse", rdv_pkg::OFS_PULSE, 32'h0);
    end
    rd("ctrl cleared", rdv_pkg::OFS_MOTHER_CTRL, 32'h0);
    wr(rdv_pkg::OFS_SLICE, 32'h3);
    tick(1);
    pcnt[0] = 0;
    srst_n = 1'b0;
    tick(10);
    srst_n = 1'b1;
    tick(60);
    check("bus reset", 32'h1, 32'(pcnt[0] >= 30));
    rd("slice cleared", rdv_pkg::OFS_SLICE, 32'h0);
    $display("test pulses done");
    r = rnd();
    wr(rdv_pkg::OFS_CRATE_MOD, {r, r});
    e = {8'h0, r[7:0], r};
    rd("crate", rdv_pkg::OFS_CRATE_MOD, e);
    check("crate pin", e, 32'(crate));
    wr(rdv_pkg::OFS_REGION, {r, r});
    rd("region", rdv_pkg::OFS_REGION, {16'h0, r});
    check("region pin", {16'h0, r}, 32'(region));
    wr(rdv_pkg::OFS_PROGRAM, 32'h1);
    rd("program", rdv_pkg::OFS_PROGRAM, 32'h1);
    check("program pin", 32'h1, 32'(cfg));
    wr(rdv_pkg::OFS_IRQ_CTRL, {r, ~r});
    rd("interrupt", rdv_pkg::OFS_IRQ_CTRL, {r, ~r});
    e = 32'h0;
    for (int s = 0; s < 10; s++) begin
      wr(rdv_pkg::OFS_SLICE, 32'(s));
      if (s >= 1 && s <= 5) e = 32'(s);
      rd("slice", rdv_pkg::OFS_SLICE, e);
      check("slice pin", e, 32'(slice));
    end
    for (int k = 0; k < 5; k++) begin
      rd("revision", rofs[k], {8'h01, fn[k], MTYPE});
    end
    $display("test words done");
    check("reads left", 32'h0, 32'(exp_q.size()));
    check("bus timeout", 32'h0, 32'(tmo));
    stop_test();
  end
endmodule
